// ===== fsps_flash_model.sv
// Flash array stand-in: ends every started operation after a delay the bench chooses
module fsps_flash_model (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       start_i,
  input  wire logic [7:0] dly_i,
  output logic            done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_ff;
  logic       run_ff;
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (!rstn_i) begin
      run_ff <= 1'b0;
      cnt_ff <= 8'h00;
    end else if (start_i) begin
      run_ff <= 1'b1;
      cnt_ff <= dly_i;
    end else if (run_ff && cnt_ff == 8'h00) begin
      run_ff <= 1'b0;
      done_o <= 1'b1;
    end else if (run_ff) begin
      cnt_ff <= cnt_ff - 8'h01;
    end
  end
endmodule : fsps_flash_model

// ===== fsps_pkg.sv
// Shared constants, types and register map of the flash self-program sequencer
package fsps_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_PTR_LO  = 8'h04;
  localparam logic [7:0] OFS_PTR_HI  = 8'h08;
  localparam logic [7:0] OFS_PTR_EXT = 8'h0c;
  localparam logic [7:0] OFS_DATA    = 8'h10;
  localparam logic [7:0] OFS_STORE   = 8'h14;
  localparam logic [7:0] OFS_LOCK    = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1c;

  // Control register bit positions and command field width
  localparam int unsigned CB_EN   = 0;
  localparam int unsigned CB_IE   = 7;
  localparam int unsigned CB_BUSY = 6;
  localparam int unsigned CMD_W   = 5;

  // Command patterns in control bits 4:0
  localparam logic [4:0] CMD_LOAD  = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_LOCK  = 5'h09;
  localparam logic [4:0] CMD_REEN  = 5'h11;

  // Store must follow the control write within this many cycles
  localparam logic [2:0] ARM_WINDOW = 3'h4;

  // Pointer and page geometry
  localparam int unsigned PTR_W      = 18;
  localparam int unsigned EXT_USED   = 2;
  localparam int unsigned WORD_IDX_W = 7;
  localparam int unsigned PAGE_IDX_W = 10;
  localparam int unsigned PC_W       = 17;
  localparam int unsigned DATA_W     = 16;

  // Lock byte: unprogrammed bits read one
  localparam logic [7:0] LOCK_RESET  = 8'hff;
  localparam int unsigned LB_APP_WP  = 2;
  localparam int unsigned LB_BOOT_WP = 4;
  localparam logic [PC_W-1:0] APP_RESET_ADDR = 17'h00000;
  localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;

  typedef enum logic [1:0] {
    FSPS_IDLE  = 2'b00,
    FSPS_ARMED = 2'b01,
    FSPS_BUSY  = 2'b10
  } fsps_state_e;

  typedef enum logic [1:0] {
    FSPS_OP_NONE  = 2'b00,
    FSPS_OP_ERASE = 2'b01,
    FSPS_OP_WRITE = 2'b10
  } fsps_op_e;

  typedef struct packed {
    fsps_op_e              op;
    logic [PAGE_IDX_W-1:0] page;
    logic                  stall;
  } fsps_flash_cmd_s;

endpackage : fsps_pkg

// ===== fsps_sequencer.sv
// Flash self-program sequencer: Wishbone registers, page buffer and flash command control
//
// The placing of the registers and the Wishbone register port were left to the implementer.
module fsps_sequencer #(
  parameter logic [fsps_pkg::PAGE_IDX_W-1:0] STALL_FIRST_PAGE = 10'h380,
  parameter logic [fsps_pkg::PAGE_IDX_W-1:0] BOOT_FIRST_PAGE  = 10'h3e0,
  parameter logic [fsps_pkg::PC_W-1:0]       BOOT_RESET_ADDR  = 17'h1f000
) (
  input  wire logic                            clk_i,
  input  wire logic                            rstn_i,
  input  wire logic                            wb_cyc_i,
  input  wire logic                            wb_stb_i,
  input  wire logic                            wb_we_i,
  input  wire logic [7:0]                      wb_adr_i,
  input  wire logic [3:0]                      wb_sel_i,
  input  wire logic [31:0]                     wb_dat_i,
  output logic      [31:0]                     wb_dat_o,
  output logic                                 wb_ack_o,
  input  wire logic                            boot_exec_i,
  input  wire logic                            eeprom_busy_i,
  input  wire logic                            chip_erase_i,
  input  wire logic                            ext_lock_wr_i,
  input  wire logic [5:0]                      ext_lock_data_i,
  input  wire logic                            boot_rst_fuse_i,
  output fsps_pkg::fsps_flash_cmd_s            flash_cmd_o,
  output logic                                 flash_start_o,
  input  wire logic                            flash_done_i,
  input  wire logic [fsps_pkg::WORD_IDX_W-1:0] flash_buf_idx_i,
  output logic      [fsps_pkg::DATA_W-1:0]     flash_buf_data_o,
  output logic                                 cpu_halt_o,
  output logic                                 rww_readable_o,
  output logic      [fsps_pkg::PC_W-1:0]       reset_vector_o,
  output logic      [fsps_pkg::PTR_W-1:0]      load_addr_o,
  output logic                                 load_byte_hi_o,
  output logic                                 irq_o
);

  localparam int unsigned WORDS = 1 << fsps_pkg::WORD_IDX_W;

  function automatic logic [fsps_pkg::WORD_IDX_W-1:0] word_of(
    input logic [fsps_pkg::PTR_W-1:0] p);
    word_of = p[fsps_pkg::WORD_IDX_W:1];
  endfunction : word_of

  function automatic logic [fsps_pkg::PAGE_IDX_W-1:0] page_of(
    input logic [fsps_pkg::PTR_W-1:0] p);
    page_of = p[fsps_pkg::PTR_W-1:fsps_pkg::WORD_IDX_W+1];
  endfunction : page_of

  function automatic logic in_stall(input logic [fsps_pkg::PAGE_IDX_W-1:0] pg);
    in_stall = (pg >= STALL_FIRST_PAGE);
  endfunction : in_stall

  // Registers
  fsps_pkg::fsps_state_e     state_ff;
  logic [7:0]                ctrl_ff;
  logic [2:0]                arm_cnt_ff;
  logic [7:0]                ptr_lo_ff;
  logic [7:0]                ptr_hi_ff;
  logic [7:0]                ptr_ext_ff;
  logic [fsps_pkg::DATA_W-1:0] data_ff;
  logic [7:0]                lock_ff;
  logic                      rww_busy_ff;
  logic                      rww_rd_ff;
  logic                      ack_ff;
  logic [31:0]               dat_ff;
  logic [WORDS-1:0]          buf_vld_ff;
  logic [fsps_pkg::DATA_W-1:0] buf_mem [WORDS];
  fsps_pkg::fsps_flash_cmd_s cmd_ff;
  logic                      start_ff;
  logic                      halt_ff;
  logic                      irq_ff;
  logic [fsps_pkg::DATA_W-1:0] buf_rd_ff;
  logic [fsps_pkg::PC_W-1:0] rst_vec_ff;
  logic [1:0]                vec_wait_ff;
  logic [1:0]                erase_sync_ff;
  logic [1:0]                lkwr_sync_ff;
  logic [1:0]                fuse_sync_ff;
  logic [5:0]                lkd_meta_ff;
  logic [5:0]                lkd_sync_ff;
  logic                      lkwr_prev_ff;

  // Bus decode; a write takes effect on the edge where ack is seen high
  logic                        wb_wr;
  logic                        wb_new;
  logic [fsps_pkg::PTR_W-1:0]  ptr;
  logic [fsps_pkg::CMD_W-1:0]  cmd;
  logic                        store;
  logic                        can_prog;
  logic                        ctrl_wr;
  logic                        wp_hit;
  logic [fsps_pkg::PAGE_IDX_W-1:0] tgt_page;

  assign wb_new  = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wb_wr   = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;
  assign ctrl_wr = wb_wr && (wb_adr_i == fsps_pkg::OFS_CTRL) && wb_sel_i[0];
  assign ptr     = {ptr_ext_ff[fsps_pkg::EXT_USED-1:0], ptr_hi_ff, ptr_lo_ff};
  assign tgt_page = page_of(ptr);
  assign cmd     = ctrl_ff[fsps_pkg::CMD_W-1:0];
  // Store issued from the application section is dropped silently
  assign store   = wb_wr && (wb_adr_i == fsps_pkg::OFS_STORE) && boot_exec_i;
  // Only LB_BOOT_WP (boot pages) and LB_APP_WP (other pages) gate erase and write stores; general lock modes are not consulted
  assign wp_hit  = (tgt_page >= BOOT_FIRST_PAGE) ? !lock_ff[fsps_pkg::LB_BOOT_WP]
                                                 : !lock_ff[fsps_pkg::LB_APP_WP];
  // EEPROM writes block all self-programming
  assign can_prog = (state_ff == fsps_pkg::FSPS_ARMED) && store && !eeprom_busy_i;

  // Wishbone slave handshake: ack one cycle after the request, for one cycle
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= wb_new;
      if (wb_new && !wb_we_i) begin
        case (wb_adr_i)
          fsps_pkg::OFS_CTRL:    dat_ff <= {24'h00_0000, ctrl_ff[7], rww_busy_ff,
                                            ctrl_ff[5:0]};
          fsps_pkg::OFS_PTR_LO:  dat_ff <= {24'h00_0000, ptr_lo_ff};
          fsps_pkg::OFS_PTR_HI:  dat_ff <= {24'h00_0000, ptr_hi_ff};
          fsps_pkg::OFS_PTR_EXT: dat_ff <= {24'h00_0000, ptr_ext_ff};
          fsps_pkg::OFS_DATA:    dat_ff <= {16'h0000, data_ff};
          fsps_pkg::OFS_LOCK:    dat_ff <= {24'h00_0000, lock_ff};
          fsps_pkg::OFS_STATUS:  dat_ff <= {28'h000_0000, fuse_sync_ff[1], halt_ff,
                                            state_ff};
          default:               dat_ff <= 32'h0000_0000;
        endcase
      end else begin
        dat_ff <= 32'h0000_0000;
      end
    end
  end

  // Pointer and data registers, plain byte-lane writes
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ptr_lo_ff  <= 8'h00;
      ptr_hi_ff  <= 8'h00;
      ptr_ext_ff <= 8'h00;
      data_ff    <= 16'h0000;
    end else if (wb_wr) begin
      if (wb_adr_i == fsps_pkg::OFS_PTR_LO && wb_sel_i[0]) begin
        ptr_lo_ff <= wb_dat_i[7:0];
      end
      if (wb_adr_i == fsps_pkg::OFS_PTR_HI && wb_sel_i[0]) begin
        ptr_hi_ff <= wb_dat_i[7:0];
      end
      if (wb_adr_i == fsps_pkg::OFS_PTR_EXT && wb_sel_i[0]) begin
        ptr_ext_ff <= wb_dat_i[7:0];
      end
      if (wb_adr_i == fsps_pkg::OFS_DATA) begin
        if (wb_sel_i[0]) begin
          data_ff[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          data_ff[15:8] <= wb_dat_i[15:8];
        end
      end
    end
  end

  // Control register and sequencing state
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_ff    <= fsps_pkg::FSPS_IDLE;
      ctrl_ff     <= 8'h00;
      arm_cnt_ff  <= 3'h0;
      rww_busy_ff <= 1'b0;
      rww_rd_ff   <= 1'b1;
      cmd_ff      <= '0;
      start_ff    <= 1'b0;
      halt_ff     <= 1'b0;
    end else begin
      start_ff <= 1'b0;
      case (state_ff)
        fsps_pkg::FSPS_IDLE: begin
          if (ctrl_wr) begin
            ctrl_ff[fsps_pkg::CB_IE] <= wb_dat_i[fsps_pkg::CB_IE];
            if (wb_dat_i[4:0] == fsps_pkg::CMD_REEN) begin
              rww_busy_ff <= 1'b0;
              rww_rd_ff   <= 1'b1;
            end else if (wb_dat_i[fsps_pkg::CB_EN]) begin
              ctrl_ff[fsps_pkg::CMD_W-1:0] <= wb_dat_i[fsps_pkg::CMD_W-1:0];
              state_ff   <= fsps_pkg::FSPS_ARMED;
              arm_cnt_ff <= 3'h0;
            end
          end
        end
        fsps_pkg::FSPS_ARMED: begin
          arm_cnt_ff <= arm_cnt_ff + 3'h1;
          if (can_prog) begin
            // Address is latched here; later pointer writes do not disturb the op
            cmd_ff.page  <= tgt_page;
            cmd_ff.stall <= in_stall(tgt_page);
            if ((cmd == fsps_pkg::CMD_ERASE || cmd == fsps_pkg::CMD_WRITE) && !wp_hit) begin
              cmd_ff.op <= (cmd == fsps_pkg::CMD_ERASE) ? fsps_pkg::FSPS_OP_ERASE
                                                        : fsps_pkg::FSPS_OP_WRITE;
              start_ff  <= 1'b1;
              state_ff  <= fsps_pkg::FSPS_BUSY;
              if (in_stall(tgt_page)) begin
                halt_ff <= 1'b1;
              end else begin
                rww_busy_ff <= 1'b1;
                rww_rd_ff   <= 1'b0;
              end
            end else begin
              // Load, lock and refused commands finish at once
              ctrl_ff[fsps_pkg::CMD_W-1:0] <= 5'h00;
              state_ff <= fsps_pkg::FSPS_IDLE;
            end
          end else if (arm_cnt_ff == fsps_pkg::ARM_WINDOW - 3'h1) begin
            ctrl_ff[fsps_pkg::CMD_W-1:0] <= 5'h00;
            state_ff <= fsps_pkg::FSPS_IDLE;
          end
        end
        fsps_pkg::FSPS_BUSY: begin
          if (flash_done_i) begin
            ctrl_ff[fsps_pkg::CMD_W-1:0] <= 5'h00;
            cmd_ff.op <= fsps_pkg::FSPS_OP_NONE;
            halt_ff   <= 1'b0;
            state_ff  <= fsps_pkg::FSPS_IDLE;
          end
        end
        default: begin
          state_ff <= fsps_pkg::FSPS_IDLE;
        end
      endcase
    end
  end

  // Temporary page buffer; unloaded words read as erased
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      buf_vld_ff <= '0;
    end else if (state_ff == fsps_pkg::FSPS_BUSY && flash_done_i &&
                 cmd_ff.op == fsps_pkg::FSPS_OP_WRITE) begin
      buf_vld_ff <= '0;
    end else if (state_ff == fsps_pkg::FSPS_IDLE && ctrl_wr &&
                 wb_dat_i[4:0] == fsps_pkg::CMD_REEN) begin
      buf_vld_ff <= '0;
    end else if (can_prog && cmd == fsps_pkg::CMD_LOAD) begin
      // Any word order is accepted; EEPROM activity never clears loaded words
      buf_vld_ff[word_of(ptr)] <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (can_prog && cmd == fsps_pkg::CMD_LOAD) begin
      buf_mem[word_of(ptr)] <= data_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      buf_rd_ff <= fsps_pkg::ERASED_WORD;
    end else begin
      buf_rd_ff <= buf_vld_ff[flash_buf_idx_i] ? buf_mem[flash_buf_idx_i]
                                               : fsps_pkg::ERASED_WORD;
    end
  end

  // External programming pins pass two flops before use
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      erase_sync_ff <= 2'b00;
      lkwr_sync_ff  <= 2'b00;
      fuse_sync_ff  <= 2'b11;
      lkd_meta_ff   <= 6'h3f;
      lkd_sync_ff   <= 6'h3f;
      lkwr_prev_ff  <= 1'b0;
    end else begin
      erase_sync_ff <= {erase_sync_ff[0], chip_erase_i};
      lkwr_sync_ff  <= {lkwr_sync_ff[0], ext_lock_wr_i};
      fuse_sync_ff  <= {fuse_sync_ff[0], boot_rst_fuse_i};
      lkd_meta_ff   <= ext_lock_data_i;
      lkd_sync_ff   <= lkd_meta_ff;
      lkwr_prev_ff  <= lkwr_sync_ff[1];
    end
  end

  // Lock bits can only be programmed (cleared to zero) except by chip erase or reset
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      lock_ff <= fsps_pkg::LOCK_RESET;
    end else if (erase_sync_ff[1]) begin
      lock_ff <= fsps_pkg::LOCK_RESET;
    end else if (lkwr_sync_ff[1] && !lkwr_prev_ff) begin
      lock_ff[5:0] <= lock_ff[5:0] & lkd_sync_ff;
    end else if (can_prog && cmd == fsps_pkg::CMD_LOCK) begin
      lock_ff[5:0] <= lock_ff[5:0] & data_ff[5:0];
    end
  end

  // Fuse is read-only to software; sampled until both sync stages hold its level
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      vec_wait_ff <= 2'h0;
      rst_vec_ff  <= fsps_pkg::APP_RESET_ADDR;
    end else if (vec_wait_ff != '1) begin
      vec_wait_ff <= vec_wait_ff + 2'h1;
      rst_vec_ff   <= fuse_sync_ff[1] ? fsps_pkg::APP_RESET_ADDR : BOOT_RESET_ADDR;
    end
  end

  // Program load address is a byte address; bit zero picks the byte
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      load_addr_o    <= '0;
      load_byte_hi_o <= 1'b0;
    end else begin
      load_addr_o    <= ptr;
      load_byte_hi_o <= ptr[0];
    end
  end

  // Interrupt is level while the enable bit is clear
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= (state_ff == fsps_pkg::FSPS_IDLE) && ctrl_ff[fsps_pkg::CB_IE] &&
                !(ctrl_wr && wb_dat_i[fsps_pkg::CB_EN]);
    end
  end

  assign wb_ack_o         = ack_ff;
  assign wb_dat_o         = dat_ff;
  assign flash_cmd_o      = cmd_ff;
  assign flash_start_o    = start_ff;
  assign flash_buf_data_o = buf_rd_ff;
  assign cpu_halt_o       = halt_ff;
  assign rww_readable_o   = rww_rd_ff;
  assign reset_vector_o   = rst_vec_ff;
  assign irq_o            = irq_ff;

  // Checks
  a_halt_stall_op: assert property (@(posedge clk_i) disable iff (!rstn_i)
    start_ff |-> (halt_ff == cmd_ff.stall) && (cmd_ff.stall || rww_busy_ff))
    else $error("halt or busy does not match target section");
  a_no_halt_rww: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (state_ff == fsps_pkg::FSPS_BUSY && !cmd_ff.stall) |-> !halt_ff)
    else $error("CPU halted during concurrent-read operation");
  a_arm_timeout: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ($rose(state_ff == fsps_pkg::FSPS_ARMED) ##0 !store [*4]) |=>
      state_ff == fsps_pkg::FSPS_IDLE && ctrl_ff[4:0] == 5'h00)
    else $error("command bits did not self-clear after four cycles");
  a_app_store_dead: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (wb_wr && wb_adr_i == fsps_pkg::OFS_STORE && !boot_exec_i) |=> !start_ff)
    else $error("store from application section started an operation");
  a_page_latched: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (state_ff == fsps_pkg::FSPS_BUSY && $past(state_ff == fsps_pkg::FSPS_BUSY))
      |-> $stable(cmd_ff.page))
    else $error("latched page changed during operation");
  a_irq_level: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (state_ff == fsps_pkg::FSPS_BUSY ##1 state_ff == fsps_pkg::FSPS_IDLE &&
     ctrl_ff[fsps_pkg::CB_IE] && !ctrl_wr) |=> irq_o)
    else $error("interrupt not raised after completion");

  a_buf_clear_wr: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (state_ff == fsps_pkg::FSPS_BUSY && flash_done_i &&
     cmd_ff.op == fsps_pkg::FSPS_OP_WRITE) |=> buf_vld_ff == '0 ##1 irq_o || !ctrl_ff[7])
    else $error("page buffer not cleared after page write");

  a_busy_reen: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (state_ff == fsps_pkg::FSPS_IDLE && ctrl_wr && wb_dat_i[4:0] == fsps_pkg::CMD_REEN)
      |=> !rww_busy_ff && rww_readable_o)
    else $error("re-enable did not clear busy flag");

  a_ack_single: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (wb_cyc_i && wb_stb_i && !ack_ff) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not exactly one cycle");

endmodule : fsps_sequencer

// ===== test_flash_self_program_sequencer.sv
// Self-checking bench for the flash self-program sequencer
module test_flash_self_program_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [16:0] BOOT_VEC = 17'h1f000;
  logic        clk_i = 1'b0, rstn_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, boot = 1'b1;
  logic        eeb = 1'b0, cerase = 1'b0, fuse = 1'b1, ack, start, done, halt, rdbl, lbh, irq;
  logic        lkwr = 1'b0;
  logic [7:0]  adr = 8'h00, dly = 8'h05;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic [6:0]  bidx = 7'h00;
  logic [15:0] bdat, mem [8];
  logic [16:0] rvec;
  logic [17:0] laddr;
  fsps_pkg::fsps_flash_cmd_s cmd;
  int          error_cnt = 0, samples_checked = 0, seed = 69;

  fsps_sequencer #(.BOOT_RESET_ADDR(BOOT_VEC)) u_fsps_sequencer (
    .clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .boot_exec_i(boot), .eeprom_busy_i(eeb), .chip_erase_i(cerase), .ext_lock_wr_i(lkwr),
    .ext_lock_data_i(6'h2f), .boot_rst_fuse_i(fuse), .flash_cmd_o(cmd), .flash_start_o(start),
    .flash_done_i(done), .flash_buf_idx_i(bidx), .flash_buf_data_o(bdat), .cpu_halt_o(halt),
    .rww_readable_o(rdbl), .reset_vector_o(rvec), .load_addr_o(laddr),
    .load_byte_hi_o(lbh), .irq_o(irq));
  fsps_flash_model u_fsps_flash_model (
    .clk_i(clk_i), .rstn_i(rstn_i), .start_i(start), .dly_i(dly), .done_o(done));

  initial forever #12.5 clk_i = ~clk_i;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Holds the request until ack is seen at an edge, then idles one cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (ack !== 1'b1) error_cnt++;
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic set_ptr(input logic [17:0] p);
    wb(1'b1, fsps_pkg::OFS_PTR_LO, {24'h0, p[7:0]});
    wb(1'b1, fsps_pkg::OFS_PTR_HI, {24'h0, p[15:8]});
    wb(1'b1, fsps_pkg::OFS_PTR_EXT, {30'h0, p[17:16]});
  endtask : set_ptr

  // Store follows the control write directly, inside the arming window
  task automatic cmd_op(input logic [7:0] ctl, input logic [17:0] p);
    set_ptr(p);
    wb(1'b1, fsps_pkg::OFS_CTRL, {24'h0, ctl});
    wb(1'b1, fsps_pkg::OFS_STORE, 32'h0);
  endtask : cmd_op

  task automatic buf_rd(input logic [6:0] i, input logic [15:0] e);
    bidx <= i;
    repeat (2) @(posedge clk_i);
    chk("buf_word", e, bdat);
  endtask : buf_rd

  task automatic reen();
    wb(1'b1, fsps_pkg::OFS_CTRL, 32'h11);
    wb(1'b0, fsps_pkg::OFS_CTRL, 32'h0);
    chk("busy_clr", 0, rd[6]);
    chk("rww_open", 1, rdbl);
  endtask : reen

  task automatic do_op(input logic [7:0] ctl, input logic [9:0] pg);
    logic st;
    int   n;
    st = pg >= 10'h380;
    n = 0;
    dly <= 8'd20 + 8'($random(seed) & 15);
    cmd_op(ctl, {pg, 8'h00});
    set_ptr(18'h3ffff);
    chk("page", pg, cmd.page);
    chk("stall", st, cmd.stall);
    chk("halt", st, halt);
    if (!st) chk("rww_read", 0, rdbl);
    while (cmd.op !== fsps_pkg::FSPS_OP_NONE && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    chk("op_done", fsps_pkg::FSPS_OP_NONE, cmd.op);
    @(posedge clk_i);
    chk("halt_end", 0, halt);
    wb(1'b0, fsps_pkg::OFS_CTRL, 32'h0);
    chk("busy", !st, rd[6]);
    chk("enable", 0, rd[0]);
  endtask : do_op

  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  initial begin
    #(25 * 20000);
    error_cnt++;
    print_verdict();
  end

  initial begin
    logic [17:0] p;
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("rst_vec", 0, rvec);
    wb(1'b0, fsps_pkg::OFS_LOCK, 32'h0);
    chk("lock_rst", 8'hff, rd);
    wb(1'b0, 8'h24, 32'h0);
    chk("unmapped", 0, rd);
    p = 18'($random(seed));
    set_ptr(p);
    @(posedge clk_i);
    chk("load_addr", p, laddr);
    chk("byte_hi", p[0], lbh);
    wb(1'b1, fsps_pkg::OFS_DATA, 32'h3c);
    cmd_op(8'h09, 18'h1);
    do_op(8'h03, 10'h012);
    reen();
    for (int k = 0; k < 8; k++) begin
      mem[k] = 16'($random(seed));
      // EEPROM busy only while the fifth word (k == 4) is staged; a store during it would be refused
      eeb <= (k == 4);
      wb(1'b1, fsps_pkg::OFS_DATA, {16'h0, mem[k]});
      eeb <= 1'b0;
      cmd_op(8'h01, {10'h012, 7'h5a - 7'(k * 17), 1'b0});
    end
    for (int k = 0; k < 8; k++) buf_rd(7'h5a - 7'(k * 17), mem[k]);
    buf_rd(7'h00, 16'hffff);
    do_op(8'h05, 10'h012);
    buf_rd(7'h5a, 16'hffff);
    reen();
    do_op(8'h83, 10'h385);
    repeat (2) @(posedge clk_i);
    chk("irq", 1, irq);
    wb(1'b1, fsps_pkg::OFS_CTRL, 32'h03);
    repeat (6) @(posedge clk_i);
    wb(1'b1, fsps_pkg::OFS_STORE, 32'h0);
    wb(1'b0, fsps_pkg::OFS_CTRL, 32'h0);
    chk("late_store", 0, {rd[4:0], start});
    boot <= 1'b0;
    cmd_op(8'h03, 18'h01200);
    chk("app_store", 1, rdbl);
    boot <= 1'b1;
    wb(1'b1, fsps_pkg::OFS_DATA, 32'h2b);
    cmd_op(8'h09, 18'h1);
    cmd_op(8'h03, 18'h01200);
    chk("protected", 1, rdbl);
    wb(1'b0, fsps_pkg::OFS_LOCK, 32'h0);
    chk("lock_fill", 8'he8, rd);
    cerase <= 1'b1;
    repeat (4) @(posedge clk_i);
    cerase <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(1'b0, fsps_pkg::OFS_LOCK, 32'h0);
    chk("lock_clr", 8'hff, rd);
    lkwr <= 1'b1;
    repeat (4) @(posedge clk_i);
    lkwr <= 1'b0;
    wb(1'b0, fsps_pkg::OFS_LOCK, 32'h0);
    chk("lock_ext", 8'hef, rd);
    wb(1'b1, fsps_pkg::OFS_DATA, 32'h77);
    cmd_op(8'h01, 18'h0);
    fuse <= 1'b0;
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    wb(1'b1, fsps_pkg::OFS_STATUS, 32'h8);
    wb(1'b0, fsps_pkg::OFS_STATUS, 32'h0);
    chk("fuse_ro", 0, rd[3]);
    chk("boot_vec", BOOT_VEC, rvec);
    buf_rd(7'h00, 16'hffff);
    print_verdict();
  end
endmodule : test_flash_self_program_sequencer
